// ### hw/hs_switch_ctrl.sv
// Second cyclic timer and high-side switch source control register bank
`timescale 1ns/1ps
`include "hs_switch_regs.svh"
module hs_switch_ctrl #(
  parameter int N_SW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire hs_switch_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic restart_mode,
  input wire logic cyclic_sense,
  input wire hs_switch_pkg::supply_fault_t fault,
  input wire logic [N_SW-1:0] sw_overload,
  input wire logic first_timer_out,
  input wire logic first_duty_out,
  input wire logic second_duty_out,
  output logic [N_SW-1:0] sw_drive,
  output logic second_timer_out
);
  logic [7:0] timer_ff;
  logic [7:0] sd_ff;
  logic [7:0] src_a_ff;
  logic [7:0] src_b_ff;
  logic [15:0] saved_ff;
  logic shut_ff;
  logic [15:0] tick_cnt_ff;
  logic tick;
  logic [15:0] per_cnt_ff;
  logic [7:0] on_cnt_ff;
  hs_switch_pkg::tmr_state_t state_ff;
  hs_switch_pkg::tmr_state_t nxt_state;
  logic [2:0] on_code;
  logic [2:0] per_code;
  logic [7:0] on_ticks;
  logic [15:0] per_ticks;
  logic t2_level;
  logic shut_now;
  logic [15:0] src_all;
  logic [15:0] src_clear;
  logic [15:0] wr_val;
  logic [1:0] wr_hit;
  logic sw_cleared;
  logic ov_shut;
  logic uv_shut;
  logic restore;
  logic [15:0] nxt_src;
  logic [N_SW-1:0] drv_sel;

  assign on_code = timer_ff[`ON_LSB +: 3];
  assign per_code = timer_ff[`PER_LSB +: 3];
  assign src_all = {src_b_ff, src_a_ff};
  // An unmasked supply fault forces every source to off
  assign ov_shut = fault.ov & ~sd_ff[`BIT_OV_KEEP];
  assign uv_shut = fault.uv & ~sd_ff[`BIT_UV_KEEP];
  assign shut_now = ov_shut | uv_shut;

  // On-time in 0.1 ms ticks
  always_comb begin
    case (on_code)
      3'h1: on_ticks = `ON_TICKS_100US;
      3'h2: on_ticks = `ON_TICKS_300US;
      3'h3: on_ticks = `ON_TICKS_1MS;
      3'h4: on_ticks = `ON_TICKS_10MS;
      3'h5: on_ticks = `ON_TICKS_20MS;
      default: on_ticks = 8'h00;
    endcase
  end

  // Period in 0.1 ms ticks
  always_comb begin
    case (per_code)
      3'h0: per_ticks = `PER_TICKS_10MS;
      3'h1: per_ticks = `PER_TICKS_20MS;
      3'h2: per_ticks = `PER_TICKS_50MS;
      3'h3: per_ticks = `PER_TICKS_100MS;
      3'h4: per_ticks = `PER_TICKS_200MS;
      3'h5: per_ticks = `PER_TICKS_1S;
      3'h6: per_ticks = `PER_TICKS_2S;
      default: per_ticks = 16'h0000;
    endcase
  end

  // Per-switch overload clears, and masked write data
  genvar g;
  generate
    for (g = 0; g < N_SW; g++) begin : g_sw
      assign src_clear[g*4 +: 4] = {4{sw_overload[g]}};
    end
  endgenerate

  assign wr_hit[0] = req.wr_en && (req.addr == `ADDR_SRC_A);
  assign wr_hit[1] = req.wr_en && (req.addr == `ADDR_SRC_B);
  always_comb begin
    wr_val = src_all;
    if (wr_hit[0]) begin
      wr_val[7:0] = req.wdata & `TMASK_SRC;
    end
    if (wr_hit[1]) begin
      wr_val[15:8] = req.wdata & `TMASK_SRC;
    end
    wr_val = wr_val & ~src_clear;
    if (shut_now) begin
      wr_val = 16'h0000;
    end
  end
  // Any path that empties both source registers counts as a clear
  assign sw_cleared = (src_all != 16'h0000) && (wr_val == 16'h0000);

  // Fault status, and a snapshot of the sources taken before the forced clear lands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_ff <= 16'h0000;
      shut_ff <= 1'b0;
    end else if (soft_rst) begin
      saved_ff <= 16'h0000;
      shut_ff <= 1'b0;
    end else begin
      shut_ff <= shut_now;
      if (shut_now && !shut_ff) begin
        saved_ff <= src_all & ~src_clear;
      end
    end
  end

  // Restore only on the cycle the fault goes away, and only with recovery enabled
  assign restore = !shut_now && shut_ff && sd_ff[`BIT_RECOVER];
  assign nxt_src = restore ? (saved_ff & ~src_clear) : wr_val;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_a_ff <= `REG_RESET;
    end else if (soft_rst) begin
      src_a_ff <= `REG_RESET;
    end else begin
      src_a_ff <= nxt_src[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_b_ff <= `REG_RESET;
    end else if (soft_rst) begin
      src_b_ff <= `REG_RESET;
    end else begin
      src_b_ff <= nxt_src[15:8];
    end
  end

  // Shutdown control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_ff <= `REG_RESET;
    end else if (soft_rst) begin
      sd_ff <= `REG_RESET;
    end else if (req.wr_en && req.addr == `ADDR_SD_CTRL) begin
      sd_ff <= req.wdata & `TMASK_SD;
    end
  end

  // Second timer control register; the restart clear wins over a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= `REG_RESET;
    end else if (soft_rst) begin
      timer_ff <= `REG_RESET;
    end else if (restart_mode && cyclic_sense && sw_cleared) begin
      timer_ff <= `REG_RESET;
    end else if (req.wr_en && req.addr == `ADDR_TIMER_CTRL) begin
      timer_ff <= req.wdata & `TMASK_TIMER;
    end
  end

  // 0.1 ms tick prescaler, held while the timer is stopped so that the
  // first on-time after a start is a whole number of ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 16'h0000;
    end else if (state_ff == hs_switch_pkg::TMR_STOPPED) begin
      tick_cnt_ff <= 16'h0000;
    end else if (tick) begin
      tick_cnt_ff <= 16'h0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end
  assign tick = (tick_cnt_ff == 16'(`TICK_CYCLES - 1));

  // Timer runs once a running on-time code and valid period are written
  always_comb begin
    nxt_state = state_ff;
    if (on_ticks == 8'h00 || per_ticks == 16'h0000) begin
      nxt_state = hs_switch_pkg::TMR_STOPPED;
    end else begin
      case (state_ff)
        hs_switch_pkg::TMR_STOPPED: nxt_state = hs_switch_pkg::TMR_ON;
        hs_switch_pkg::TMR_ON: begin
          if (tick && on_cnt_ff == on_ticks - 8'h01) begin
            nxt_state = hs_switch_pkg::TMR_OFF;
          end
        end
        hs_switch_pkg::TMR_OFF: begin
          if (tick && per_cnt_ff == per_ticks - 16'h0001) begin
            nxt_state = hs_switch_pkg::TMR_ON;
          end
        end
        default: nxt_state = hs_switch_pkg::TMR_STOPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= hs_switch_pkg::TMR_STOPPED;
      per_cnt_ff <= 16'h0000;
      on_cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state == hs_switch_pkg::TMR_STOPPED || state_ff == hs_switch_pkg::TMR_STOPPED
          || (state_ff == hs_switch_pkg::TMR_OFF && nxt_state == hs_switch_pkg::TMR_ON)) begin
        per_cnt_ff <= 16'h0000;
        on_cnt_ff <= 8'h00;
      end else if (tick) begin
        per_cnt_ff <= per_cnt_ff + 16'h0001;
        if (state_ff == hs_switch_pkg::TMR_ON) begin
          on_cnt_ff <= on_cnt_ff + 8'h01;
        end
      end
    end
  end

  always_comb begin
    if (on_code == `ON_CODE_HIGH) begin
      t2_level = 1'b1;
    end else if (on_code == `ON_CODE_LOW) begin
      t2_level = 1'b0;
    end else begin
      t2_level = (state_ff == hs_switch_pkg::TMR_ON);
    end
  end

  // Source decode per switch
  generate
    for (g = 0; g < N_SW; g++) begin : g_drv
      logic [2:0] src;
      assign src = src_all[g*4 +: 3];
      always_comb begin
        case (src)
          `SRC_ON: drv_sel[g] = 1'b1;
          `SRC_T1: drv_sel[g] = first_timer_out;
          `SRC_T2: drv_sel[g] = t2_level;
          `SRC_DUTY1: drv_sel[g] = first_duty_out;
          `SRC_DUTY2: drv_sel[g] = second_duty_out;
          default: drv_sel[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // A supply shutdown gates all switches in the same cycle as the source clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_drive <= '0;
    end else begin
      sw_drive <= drv_sel & ~{N_SW{shut_now}};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      second_timer_out <= 1'b0;
    end else begin
      second_timer_out <= t2_level;
    end
  end

  // Read-back, reserved bits already held at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      case (req.addr)
        `ADDR_TIMER_CTRL: rdata <= timer_ff;
        `ADDR_SD_CTRL: rdata <= sd_ff;
        `ADDR_SRC_A: rdata <= src_a_ff;
        `ADDR_SRC_B: rdata <= src_b_ff;
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule : hs_switch_ctrl

// ### pkg/hs_switch_pkg.sv
// Types shared by the switch control logic
package hs_switch_pkg;
  typedef struct packed {
    logic wr_en;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic ov;
    logic uv;
  } supply_fault_t;
  typedef enum logic [1:0] {
    TMR_STOPPED = 2'b00,
    TMR_ON = 2'b01,
    TMR_OFF = 2'b11
  } tmr_state_t;
endpackage : hs_switch_pkg

// ### pkg/hs_switch_regs.svh
// Register offsets, field positions, reset values and timing constants for the switch control
`ifndef HS_SWITCH_REGS_SVH
`define HS_SWITCH_REGS_SVH
`define ADDR_TIMER_CTRL 7'h0d
`define ADDR_SD_CTRL 7'h10
`define ADDR_SRC_A 7'h14
`define ADDR_SRC_B 7'h15
`define REG_RESET 8'h00
`define TMASK_TIMER 8'h77
`define TMASK_SD 8'h70
`define TMASK_SRC 8'h77
`define BIT_OV_KEEP 6
`define BIT_UV_KEEP 5
`define BIT_RECOVER 4
`define ON_LSB 4
`define PER_LSB 0
`define SRC_HI_LSB 4
`define CLK_HZ 20000000
`define TICK_US 100
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)
`define ON_TICKS_100US 8'h01
`define ON_TICKS_300US 8'h03
`define ON_TICKS_1MS 8'h0a
`define ON_TICKS_10MS 8'h64
`define ON_TICKS_20MS 8'hc8
`define PER_TICKS_10MS 16'h0064
`define PER_TICKS_20MS 16'h00c8
`define PER_TICKS_50MS 16'h01f4
`define PER_TICKS_100MS 16'h03e8
`define PER_TICKS_200MS 16'h07d0
`define PER_TICKS_1S 16'h2710
`define PER_TICKS_2S 16'h4e20
`define ON_CODE_LOW 3'h0
`define ON_CODE_HIGH 3'h6
`define SRC_OFF 3'h0
`define SRC_ON 3'h1
`define SRC_T1 3'h2
`define SRC_T2 3'h3
`define SRC_DUTY1 3'h4
`define SRC_DUTY2 3'h5
`endif

// ### verification/high_side_switch_control_bench.sv
// Self-checking bench for the switch control register bank
`timescale 1ns/1ps
module high_side_switch_control_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_rst = 1'b0;
  logic restart_mode = 1'b0;
  logic cyclic_sense = 1'b0;
  logic first_timer_out = 1'b1;
  logic first_duty_out = 1'b1;
  logic second_duty_out = 1'b0;
  hs_switch_pkg::reg_req_t req = '0;
  hs_switch_pkg::supply_fault_t fault = '0;
  logic [3:0] short_en = 4'h0;
  logic [3:0] sw_overload;
  logic [3:0] sw_drive;
  logic [7:0] rdata;
  logic second_timer_out;
  logic [1:0] chk = 2'h0;
  logic [7:0] lf = 8'h3e;
  logic [7:0] exp_q[$];
  logic [6:0] addrs[5] = '{7'h0d, 7'h10, 7'h14, 7'h15, 7'h20};
  logic [7:0] msk[5] = '{8'h77, 8'h70, 8'h77, 8'h77, 8'h00};
  int n_fail = 0;
  int n_tests = 0;
  hs_switch_ctrl u_dut(.clk(clk), .rst_n(rst_n), .soft_rst(soft_rst), .req(req), .rdata(rdata),
    .restart_mode(restart_mode), .cyclic_sense(cyclic_sense), .fault(fault),
    .sw_overload(sw_overload), .first_timer_out(first_timer_out),
    .first_duty_out(first_duty_out), .second_duty_out(second_duty_out),
    .sw_drive(sw_drive), .second_timer_out(second_timer_out));
  hs_load_model u_load(.clk(clk), .sw_drive(sw_drive), .short_en(short_en),
    .sw_overload(sw_overload));
  initial begin
    forever #25 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic cmp(input string what, input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, want, seen);
    end
  endtask : cmp
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, a, d};
    @(posedge clk);
    req.wr_en <= 1'b0;
  endtask : wr
  // Kind 1 checks read data, kind 2 checks timer and switch drive
  task automatic look(input logic [1:0] k, input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    req.addr <= a;
    exp_q.push_back(e);
    chk <= k;
    @(posedge clk);
    chk <= 2'h0;
  endtask : look
  always @(posedge clk) begin : mon
    logic [1:0] k;
    k = chk;
    #1;
    if (k == 2'h1) cmp("rdata", rdata, exp_q.pop_front());
    if (k == 2'h2) cmp("drive", {3'h0, second_timer_out, sw_drive}, exp_q.pop_front());
  end
  task automatic pulse_soft();
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
  endtask : pulse_soft
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) look(1, addrs[i], 8'h00);
    for (int i = 0; i < 10; i++) begin
      lf = lfsr(lf);
      wr(addrs[i % 5], lf);
      look(1, addrs[i % 5], lf & msk[i % 5]);
    end
    pulse_soft();
    look(1, 7'h14, 8'h00);
    wr(7'h0d, 8'h60);
    for (int c = 0; c < 8; c++) begin
      wr(7'h14, {1'b0, c[2:0], 1'b0, c[2:0]});
      wr(7'h15, {1'b0, c[2:0], 1'b0, c[2:0]});
      look(2, 7'h14, (c > 0 && c < 5) ? 8'h1f : 8'h10);
    end
    wr(7'h14, 8'h01);
    wr(7'h15, 8'h10);
    look(2, 7'h14, 8'h19);
    wr(7'h14, 8'h33);
    wr(7'h15, 8'h33);
    wr(7'h0d, 8'h70);
    look(2, 7'h14, 8'h00);
    wr(7'h0d, 8'h60);
    wr(7'h0d, 8'h00);
    look(2, 7'h14, 8'h00);
    wr(7'h0d, 8'h10);
    repeat (3) @(posedge clk);
    look(2, 7'h14, 8'h1f);
    repeat (2000) @(posedge clk);
    look(2, 7'h14, 8'h00);
    wr(7'h14, 8'h11);
    short_en <= 4'h1;
    repeat (5) @(posedge clk);
    look(1, 7'h14, 8'h10);
    short_en <= 4'h0;
    wr(7'h14, 8'h11);
    wr(7'h15, 8'h11);
    fault <= 2'b10;
    look(2, 7'h14, 8'h00);
    fault <= 2'b00;
    look(2, 7'h14, 8'h00);
    wr(7'h10, 8'h50);
    wr(7'h14, 8'h11);
    wr(7'h15, 8'h11);
    fault <= 2'b10;
    look(2, 7'h14, 8'h0f);
    fault <= 2'b01;
    look(2, 7'h14, 8'h00);
    fault <= 2'b00;
    look(2, 7'h14, 8'h0f);
    restart_mode <= 1'b1;
    cyclic_sense <= 1'b1;
    wr(7'h14, 8'h00);
    wr(7'h15, 8'h00);
    look(1, 7'h0d, 8'h00);
    pulse_soft();
    restart_mode <= 1'b0;
    look(1, 7'h10, 8'h00);
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule : high_side_switch_control_bench

// ### verification/hs_load_model.sv
// Load model that flags overload while shorted and driven
`timescale 1ns/1ps
module hs_load_model (
  input wire logic clk,
  input wire logic [3:0] sw_drive,
  input wire logic [3:0] short_en,
  output logic [3:0] sw_overload = 4'h0
);
  // Overload stays flagged while the short persists
  always_ff @(posedge clk) begin
    sw_overload <= short_en & (sw_overload | sw_drive);
  end
endmodule : hs_load_model

// ### verification/hs_switch_asserts.sv
// Checker for the switch control register bank
`timescale 1ns/1ps
module hs_switch_asserts #(
  parameter int N_SW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire hs_switch_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic restart_mode,
  input wire hs_switch_pkg::supply_fault_t fault,
  input wire logic [N_SW-1:0] sw_overload,
  input wire logic [N_SW-1:0] sw_drive,
  input wire logic second_timer_out
);
  logic [7:0] sd_ff;
  logic [7:0] tm_ff;
  logic [11:0] hi_ff;
  // Shadows of the bus-written shutdown and timer control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_ff <= 8'h00;
      tm_ff <= 8'h00;
    end else if (soft_rst) begin
      sd_ff <= 8'h00;
      tm_ff <= 8'h00;
    end else if (req.wr_en) begin
      if (req.addr == 7'h10) sd_ff <= req.wdata;
      if (req.addr == 7'h0d) tm_ff <= req.wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hi_ff <= 12'h000;
    else hi_ff <= second_timer_out ? hi_ff + 12'h001 : 12'h000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    req.wr_en && req.addr == 7'h0d && req.wdata[6:4] == 3'h1 && req.wdata[2:0] != 3'h7
      && tm_ff[6:4] == 3'h0 && !soft_rst && !restart_mode;
  endsequence
  sequence s_ovl;
    sw_overload[0] [*3];
  endsequence
  property p_rsv; rdata[7] == 1'b0 && rdata[3] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
  property p_sd; !req.wr_en && req.addr == 7'h10 && !soft_rst |=> rdata == (sd_ff & 8'h70); endproperty
  a_sd: assert property (p_sd) else $error("shutdown readback wrong");
  property p_ov; (fault.ov && !sd_ff[6]) [*2] |-> sw_drive == '0; endproperty
  a_ov: assert property (p_ov) else $error("switch on during overvoltage");
  property p_uv; (fault.uv && !sd_ff[5]) [*2] |-> sw_drive == '0; endproperty
  a_uv: assert property (p_uv) else $error("switch on during undervoltage");
  property p_low; (tm_ff[6:4] inside {3'h0, 3'h7} && !restart_mode) [*3] |-> !second_timer_out; endproperty
  a_low: assert property (p_low) else $error("stopped timer high");
  property p_high; (tm_ff[6:4] == 3'h6 && tm_ff[2:0] != 3'h7 && !restart_mode) [*3]
    |-> second_timer_out; endproperty
  a_high: assert property (p_high) else $error("held timer low");
  property p_start; s_start |-> ##[1:3] second_timer_out; endproperty
  a_start: assert property (p_start) else $error("timer did not start");
  property p_on; $fell(second_timer_out) && tm_ff[6:4] == 3'h1 && !restart_mode
    |-> hi_ff inside {[12'h7cf:12'h7d1]}; endproperty
  a_on: assert property (p_on) else $error("on time not 2000 cycles");
  property p_ovl; s_ovl |-> !sw_drive[0]; endproperty
  a_ovl: assert property (p_ovl) else $error("overloaded switch still on");
  property p_srst; soft_rst && !req.wr_en ##1 !req.wr_en |=> rdata == 8'h00 && sw_drive == '0; endproperty
  a_srst: assert property (p_srst) else $error("soft reset left state");
endmodule : hs_switch_asserts
bind hs_switch_ctrl hs_switch_asserts #(.N_SW(N_SW)) u_chk(.clk(clk), .rst_n(rst_n),
  .soft_rst(soft_rst), .req(req), .rdata(rdata), .restart_mode(restart_mode), .fault(fault),
  .sw_overload(sw_overload), .sw_drive(sw_drive), .second_timer_out(second_timer_out));
